// File: hdl/fpdb_params.svh
// constants for the fetch pipeline and data banking block
`ifndef FPDB_PARAMS_SVH
`define FPDB_PARAMS_SVH

// ---------------------------------------------------------------
// program side
// ---------------------------------------------------------------
`define FPDB_PTR_W 21
`define FPDB_WORD_W 16
`define FPDB_PTR_STEP 21'h000002
`define FPDB_PTR_RESET 21'h000000

// ---------------------------------------------------------------
// data side
// ---------------------------------------------------------------
`define FPDB_DADDR_W 12
`define FPDB_BANKPTR_ADDR 12'hfe0
`define FPDB_BANKPTR_RESET 4'h0
`define FPDB_FAST_SPLIT 8'h60
`define FPDB_FAST_LOW_BANK 4'h0
`define FPDB_FAST_HIGH_BANK 4'hf
`define FPDB_SFR_BASE 12'hf60
`define FPDB_IMPL_BANK_A 4'h0
`define FPDB_IMPL_BANK_B 4'h1
`define FPDB_USB_BANK 4'h4

// ---------------------------------------------------------------
// opcode fields
// ---------------------------------------------------------------
`define FPDB_OP_LDBANK 12'h010
`define FPDB_OP_INC 6'h0a
`define FPDB_OP_SKIPZ 7'h33
`define FPDB_OP_BRA 5'h1a
`define FPDB_OP_JUMP 8'hef
`define FPDB_OP_CALL 8'hec
`define FPDB_OP_MOVE 4'hc
`define FPDB_OP_SECOND 4'hf

`endif

// File: hdl/fpdb_pkg.sv
// types for the fetch pipeline and data banking block
package fpdb_pkg;

  // one-hot quadrature phase
  typedef enum logic [3:0] {
    PH_A = 4'b0001,
    PH_B = 4'b0010,
    PH_C = 4'b0100,
    PH_D = 4'b1000
  } fpdb_phase_t;

  // decoded operation of the word in the instruction latch
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_LDBANK = 4'h1,
    OP_INC = 4'h2,
    OP_SKIPZ = 4'h3,
    OP_BRA = 4'h4,
    OP_JUMP = 4'h5,
    OP_MOVE1 = 4'h6,
    OP_MOVE2 = 4'h7,
    OP_CONT = 4'h8
  } fpdb_op_t;

endpackage : fpdb_pkg

// File: hdl/fpdb_core.sv
// fetch/execute pipeline, quadrature phasing and banked data addressing
// Summary of operation
// - input clock divided by four into phases a to d, one instruction cycle
// - fetch pointer advances every phase_a; program word latched in phase_d
// - fetch of next word overlaps execute of current word, one per cycle
// - pointer-changing instructions take two cycles; a branch discards the fetched word, jump/call uses it as its second word
// - operand read in phase_b, destination written in phase_d
// - program memory byte addressed; words start at even addresses
// - fetch pointer steps by two and its low bit is always zero
// - absolute jump/call value is a word address loaded into bits 20:1
// - relative branch offset counts words, pointer moves twice offset bytes
// - second word of two-word instructions has 1111 on top, 12 literal bits
// - a lone 1111-topped word executes as a no-operation
// - 12-bit data addresses, 16 banks of 256 bytes, three banks built
// - reads of unimplemented data locations return zero
// - bank 4 is dual-port, shared with the usb engine when it is enabled
// - banked address is bank pointer on top, instruction's 8 bits below
// - only low four bank pointer bits exist; upper read zero, ignore writes
// - load_bank_literal loads the bank pointer from a literal
// - unimplemented-bank writes dropped, reads zero, status flags still update
// - mem_to_mem_move uses full 12-bit addresses and ignores bank pointer
// - other data instructions use bank pointer or the fast-access map
// - fast map puts 00h-5Fh in bank 0 and 60h-FFh at top of bank 15
// - access_select_bit one uses bank pointer, zero uses fast-access map
`timescale 1ns/1ns
`include "fpdb_params.svh"

module fpdb_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // program memory
  output logic [`FPDB_PTR_W-1:0] progAddr,
  output logic progFetch,
  input wire logic [`FPDB_WORD_W-1:0] progData,
  // data memory
  output logic [`FPDB_DADDR_W-1:0] dataAddr,
  output logic dataRdEn,
  input wire logic [7:0] dataRdData,
  output logic dataWrEn,
  output logic [7:0] dataWrData,
  // usb serial engine
  input wire logic usbEnable,
  output logic usbBufferAccess,
  // status
  output fpdb_pkg::fpdb_phase_t phase,
  output logic [7:0] bankPointer,
  output logic [7:0] workReg,
  output logic zeroFlag
);
  import fpdb_pkg::*;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // banked or fast-access address of a single-word data instruction
  function automatic logic [`FPDB_DADDR_W-1:0] formAddr(input logic sel, input logic [7:0] f,
                                                        input logic [3:0] bank);
    if (sel) begin
      formAddr = {bank, f};
    end else if (f < `FPDB_FAST_SPLIT) begin
      formAddr = {`FPDB_FAST_LOW_BANK, f};
    end else begin
      formAddr = {`FPDB_FAST_HIGH_BANK, f};
    end
  endfunction : formAddr

  // true where external data storage exists
  function automatic logic isImpl(input logic [`FPDB_DADDR_W-1:0] a);
    isImpl = (a[11:8] == `FPDB_IMPL_BANK_A) || (a[11:8] == `FPDB_IMPL_BANK_B) ||
             (a[11:8] == `FPDB_USB_BANK) ||
             ((a >= `FPDB_SFR_BASE) && (a != `FPDB_BANKPTR_ADDR));
  endfunction : isImpl

  // operation class of the latched word
  function automatic fpdb_op_t decodeOp(input logic [15:0] w, input logic valid,
                                        input logic paired, input logic pairMove);
    decodeOp = OP_NOP;
    if (!valid) begin
      decodeOp = OP_NOP;
    end else if (w[15:12] == `FPDB_OP_SECOND) begin
      // paired second word carries literal data; a lone one is a no-operation
      if (paired) begin
        decodeOp = pairMove ? OP_MOVE2 : OP_CONT;
      end else begin
        decodeOp = OP_NOP;
      end
    end else if (w[15:4] == `FPDB_OP_LDBANK) begin
      decodeOp = OP_LDBANK;
    end else if (w[15:10] == `FPDB_OP_INC) begin
      decodeOp = OP_INC;
    end else if (w[15:9] == `FPDB_OP_SKIPZ) begin
      decodeOp = OP_SKIPZ;
    end else if (w[15:11] == `FPDB_OP_BRA) begin
      decodeOp = OP_BRA;
    end else if ((w[15:8] == `FPDB_OP_JUMP) || (w[15:8] == `FPDB_OP_CALL)) begin
      decodeOp = OP_JUMP;
    end else if (w[15:12] == `FPDB_OP_MOVE) begin
      decodeOp = OP_MOVE1;
    end
  endfunction : decodeOp

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta;
  logic rstSync;

  // two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ---------------------------------------------------------------
  // pipeline state
  // ---------------------------------------------------------------
  fpdb_phase_t phase_reg, phase_next;
  logic [`FPDB_PTR_W-1:0] fetchPtr_reg, fetchPtr_next;
  logic [`FPDB_PTR_W-1:0] progAddr_reg, progAddr_next;
  logic [15:0] instrLatch_reg, instrLatch_next;
  logic execValid_reg, execValid_next;
  logic paired_reg, paired_next;
  logic pairMove_reg, pairMove_next;
  logic [`FPDB_DADDR_W-1:0] dataAddr_reg, dataAddr_next;
  logic [7:0] opData_reg, opData_next;
  logic [7:0] wrData_reg, wrData_next;
  logic wrPend_reg, wrPend_next;
  logic wrWork_reg, wrWork_next;
  logic [3:0] bank_reg, bank_next;
  logic [7:0] work_reg, work_next;
  logic zero_reg, zero_next;
  fpdb_op_t op;
  logic [`FPDB_DADDR_W-1:0] opAddr;
  logic rdNeed;
  logic [7:0] rdValue;
  logic [7:0] incValue;
  logic takeBranch;
  logic killNext;

  // decode of the word now executing
  always_comb begin
    op = decodeOp(instrLatch_reg, execValid_reg, paired_reg, pairMove_reg);
    if ((op == OP_MOVE1) || (op == OP_MOVE2)) begin
      opAddr = instrLatch_reg[11:0];
    end else begin
      opAddr = formAddr(instrLatch_reg[8], instrLatch_reg[7:0], bank_reg);
    end
    rdNeed = (op == OP_INC) || (op == OP_SKIPZ) || (op == OP_MOVE1);
    if (dataAddr_reg == `FPDB_BANKPTR_ADDR) begin
      rdValue = {4'h0, bank_reg};
    end else if (isImpl(dataAddr_reg)) begin
      rdValue = dataRdData;
    end else begin
      rdValue = 8'h00;
    end
    incValue = opData_reg + 8'h01;
    takeBranch = (op == OP_BRA) || (op == OP_JUMP);
    killNext = (op == OP_BRA) || ((op == OP_SKIPZ) && (opData_reg == 8'h00));
  end

  // next values of the pipeline, stepped by phase
  always_comb begin
    phase_next = phase_reg;
    fetchPtr_next = fetchPtr_reg;
    progAddr_next = progAddr_reg;
    instrLatch_next = instrLatch_reg;
    execValid_next = execValid_reg;
    paired_next = paired_reg;
    pairMove_next = pairMove_reg;
    dataAddr_next = dataAddr_reg;
    opData_next = opData_reg;
    wrData_next = wrData_reg;
    wrPend_next = wrPend_reg;
    wrWork_next = wrWork_reg;
    bank_next = bank_reg;
    work_next = work_reg;
    zero_next = zero_reg;
    unique case (phase_reg)
      PH_A: begin
        phase_next = PH_B;
        progAddr_next = fetchPtr_reg;
        fetchPtr_next = fetchPtr_reg + `FPDB_PTR_STEP;
        dataAddr_next = opAddr;
      end
      PH_B: begin
        phase_next = PH_C;
        if (rdNeed) begin
          opData_next = rdValue;
        end
      end
      PH_C: begin
        phase_next = PH_D;
        wrPend_next = 1'b0;
        wrWork_next = 1'b0;
        if (op == OP_INC) begin
          wrData_next = incValue;
          wrPend_next = instrLatch_reg[9];
          wrWork_next = !instrLatch_reg[9];
        end else if (op == OP_MOVE2) begin
          wrData_next = opData_reg;
          wrPend_next = 1'b1;
        end
      end
      PH_D: begin
        phase_next = PH_A;
        // destination write and status update
        if (wrPend_reg && (dataAddr_reg == `FPDB_BANKPTR_ADDR)) begin
          bank_next = wrData_reg[3:0];
        end
        if (wrWork_reg) begin
          work_next = wrData_reg;
        end
        if (op == OP_INC) begin
          zero_next = (wrData_reg == 8'h00);
        end
        if (op == OP_LDBANK) begin
          bank_next = instrLatch_reg[3:0];
        end
        // pointer redirection
        if (op == OP_BRA) begin
          fetchPtr_next = progAddr_reg +
                          {{9{instrLatch_reg[10]}}, instrLatch_reg[10:0], 1'b0};
        end else if (op == OP_JUMP) begin
          fetchPtr_next = {progData[11:0], instrLatch_reg[7:0], 1'b0};
        end
        // latch next word; a discarded word spends its cycle as a bubble
        instrLatch_next = progData;
        execValid_next = !killNext;
        paired_next = (op == OP_JUMP) || (op == OP_MOVE1);
        pairMove_next = (op == OP_MOVE1);
      end
    endcase
  end

  // pipeline registers
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      phase_reg <= PH_A;
      fetchPtr_reg <= `FPDB_PTR_RESET;
      progAddr_reg <= `FPDB_PTR_RESET;
      instrLatch_reg <= 16'h0000;
      execValid_reg <= 1'b0;
      paired_reg <= 1'b0;
      pairMove_reg <= 1'b0;
      dataAddr_reg <= 12'h000;
      opData_reg <= 8'h00;
      wrData_reg <= 8'h00;
      wrPend_reg <= 1'b0;
      wrWork_reg <= 1'b0;
      bank_reg <= `FPDB_BANKPTR_RESET;
      work_reg <= 8'h00;
      zero_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      fetchPtr_reg <= fetchPtr_next;
      progAddr_reg <= progAddr_next;
      instrLatch_reg <= instrLatch_next;
      execValid_reg <= execValid_next;
      paired_reg <= paired_next;
      pairMove_reg <= pairMove_next;
      dataAddr_reg <= dataAddr_next;
      opData_reg <= opData_next;
      wrData_reg <= wrData_next;
      wrPend_reg <= wrPend_next;
      wrWork_reg <= wrWork_next;
      bank_reg <= bank_next;
      work_reg <= work_next;
      zero_reg <= zero_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // strobes gated so no access leaves for missing storage
  assign dataRdEn = (phase_reg == PH_B) && rdNeed && isImpl(dataAddr_reg);
  assign dataWrEn = (phase_reg == PH_D) && wrPend_reg && isImpl(dataAddr_reg);
  assign usbBufferAccess = (dataRdEn || dataWrEn) && usbEnable &&
                           (dataAddr_reg[11:8] == `FPDB_USB_BANK);
  assign progFetch = (phase_reg == PH_D);
  assign progAddr = progAddr_reg;
  assign dataAddr = dataAddr_reg;
  assign dataWrData = wrData_reg;
  assign phase = phase_reg;
  assign bankPointer = {4'h0, bank_reg};
  assign workReg = work_reg;
  assign zeroFlag = zero_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSync);

  sequence s_rest_of_cycle;
    (phase_reg == PH_B) ##1 (phase_reg == PH_C) ##1 (phase_reg == PH_D) ##1 (phase_reg == PH_A);
  endsequence

  property p_phase_rotate;
    (phase_reg == PH_A) |=> s_rest_of_cycle;
  endproperty
  a_phase_rotate: assert property (p_phase_rotate) else $error("phase order broken");

  property p_fetch_step;
    (phase_reg == PH_A) && !$past(takeBranch) |=> (fetchPtr_reg == progAddr_reg + 21'h000002);
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch step wrong");

  property p_even_ptr;
    (fetchPtr_reg[0] == 1'b0) && (progAddr_reg[0] == 1'b0);
  endproperty
  a_even_ptr: assert property (p_even_ptr) else $error("odd fetch address");

  property p_read_phase;
    dataRdEn |-> (phase_reg == PH_B) && $past(phase_reg == PH_A);
  endproperty
  a_read_phase: assert property (p_read_phase) else $error("read outside phase b");

  property p_write_phase;
    dataWrEn |-> (phase_reg == PH_D) ##1 !dataWrEn [*3];
  endproperty
  a_write_phase: assert property (p_write_phase) else $error("write off phase d");

  property p_bank_upper;
    bankPointer[7:4] == 4'h0;
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper bits set");

  property p_drop_write;
    dataWrEn |-> (dataAddr != `FPDB_BANKPTR_ADDR) && ((dataAddr[11:8] inside
      {`FPDB_IMPL_BANK_A, `FPDB_IMPL_BANK_B, `FPDB_USB_BANK}) || (dataAddr >= `FPDB_SFR_BASE));
  endproperty
  a_drop_write: assert property (p_drop_write) else $error("write to missing bank");

  property p_flush;
    (phase_reg == PH_D) && (op == OP_BRA) |=> !execValid_reg [*4];
  endproperty
  a_flush: assert property (p_flush) else $error("branch did not flush");

  sequence s_orphan_cycle;
    (!dataRdEn && !dataWrEn) [*4];
  endsequence

  property p_orphan_nop;
    (phase_reg == PH_A) && execValid_reg && !paired_reg &&
    (instrLatch_reg[15:12] == 4'hf) |-> s_orphan_cycle ##1 $stable(bank_reg) && $stable(work_reg);
  endproperty
  a_orphan_nop: assert property (p_orphan_nop) else $error("orphan word acted");

  property p_ldbank;
    (phase_reg == PH_D) && (op == OP_LDBANK) |=> (bank_reg == $past(instrLatch_reg[3:0]));
  endproperty
  a_ldbank: assert property (p_ldbank) else $error("bank literal not loaded");

  property p_jump_target;
    (phase_reg == PH_D) && (op == OP_JUMP) |=>
      (fetchPtr_reg == {$past(progData[11:0]), $past(instrLatch_reg[7:0]), 1'b0});
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

endmodule : fpdb_core

// File: dv/fpdb_mem_model.sv
// program memory, data storage and usb buffer bank as seen from the core
`timescale 1ns/1ns
`include "fpdb_params.svh"

module fpdb_mem_model (
  // clock
  input wire logic ref_clk,
  // program memory
  input wire logic [`FPDB_PTR_W-1:0] progAddr,
  input wire logic progFetch,
  output logic [`FPDB_WORD_W-1:0] progData,
  // data memory
  input wire logic [`FPDB_DADDR_W-1:0] dataAddr,
  input wire logic dataRdEn,
  output logic [7:0] dataRdData,
  input wire logic dataWrEn,
  input wire logic [7:0] dataWrData
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] progMem [0:255];
  logic [7:0] dataMem [0:4095];
  logic [15:0] lastWord = 16'h0000;
  logic [7:0] lastByte = 8'h00;

  // banks 0, 1 and 4 plus the special area, bank pointer excluded
  function automatic logic isBuilt(input logic [11:0] a);
    return (a[11:8] inside {4'h0, 4'h1, 4'h4}) || (a >= 12'hf60 && a != 12'hfe0);
  endfunction : isBuilt

  // empty program space reads as no-operation words
  initial begin
    for (int i = 0; i < 256; i++) progMem[i] = 8'h00;
  end

  // ---------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------
  // word is low byte at even address, high byte at odd; idle lines show a changed value
  assign progData = progFetch ? {progMem[{progAddr[7:1], 1'b1}], progMem[{progAddr[7:1], 1'b0}]}
                              : ~lastWord;
  assign dataRdData = !dataRdEn ? ~lastByte :
                      (isBuilt(dataAddr) ? dataMem[dataAddr] : 8'h00);

  // remember last answers, store implemented writes
  always @(posedge ref_clk) begin
    if (progFetch) lastWord <= progData;
    if (dataRdEn) lastByte <= dataRdData;
    if (dataWrEn && isBuilt(dataAddr)) dataMem[dataAddr] <= dataWrData;
  end
endmodule : fpdb_mem_model

// File: dv/fpdb_core_tb.sv
// self-checking bench running a small program through the core twice
`timescale 1ns/1ns
`include "fpdb_params.svh"

module fpdb_core_tb;
  import fpdb_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic usbEnable = 1'b0;
  logic [20:0] progAddr;
  logic progFetch, dataRdEn, dataWrEn, usbBufferAccess, zeroFlag, usbExpect;
  logic [15:0] progData;
  logic [11:0] dataAddr;
  logic [7:0] dataRdData, dataWrData, bankPointer, workReg;
  fpdb_phase_t phase;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int base = 0;
  int lastFetch = 0;
  typedef struct {logic [11:0] addr; logic [7:0] data; int gap;} fpdb_note_t;
  fpdb_note_t notes[$];
  fpdb_note_t cur;
  localparam logic [15:0] PROG [0:36] = '{
    16'h0101, 16'h2b10, 16'h2a20, 16'h2a70, 16'h0102, 16'h2b05, 16'h0104, 16'h2b33,
    16'hc123, 16'hf0a5, 16'h6630, 16'hc124, 16'hf0a6, 16'h6631, 16'hc125, 16'hf0a7,
    16'h2a40, 16'h2840, 16'hd003, 16'h2a50, 16'h2a50, 16'h2a50, 16'hef20, 16'hf000,
    16'h2a51, 16'h2a51, 16'h2a51, 16'h2a51, 16'h2a51, 16'h2a51, 16'h2a51, 16'h2a51,
    16'h2a21, 16'h0102, 16'h2b00, 16'h0105, 16'hd7ff};

  assign usbExpect = usbEnable && dataAddr[11:8] == `FPDB_USB_BANK;

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  fpdb_core dut (.ref_clk(ref_clk), .rstn(rstn), .progAddr(progAddr), .progFetch(progFetch),
    .progData(progData), .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData), .usbEnable(usbEnable),
    .usbBufferAccess(usbBufferAccess), .phase(phase), .bankPointer(bankPointer),
    .workReg(workReg), .zeroFlag(zeroFlag));
  fpdb_mem_model mem (.ref_clk(ref_clk), .progAddr(progAddr), .progFetch(progFetch),
    .progData(progData), .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData),
    .dataWrEn(dataWrEn), .dataWrData(dataWrData));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
    num_checks++;
    if (seen !== expected) begin
      num_errors++;
      $display("wrong value %s: expected %0h, seen %0h", what, expected, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic note(input logic [11:0] a, input logic [7:0] d, input int g);
    notes.push_back('{a, d, g});
  endtask : note

  // random data, fixed test locations, program loaded a byte at a time
  task automatic fill_memory();
    for (int i = 0; i < 4096; i++) mem.dataMem[i] = 8'($urandom);
    mem.dataMem[12'h030] = 8'h00;
    mem.dataMem[12'h031] = mem.dataMem[12'h031] | 8'h01;
    mem.dataMem[12'h040] = 8'hff;
    mem.dataMem[12'h021] = 8'hff;
    for (int i = 0; i < 37; i++) begin
      mem.progMem[2 * i] = PROG[i][7:0];
      mem.progMem[2 * i + 1] = PROG[i][15:8];
    end
  endtask : fill_memory

  // expected writes with their spacing in instruction cycles from the first
  task automatic plan_run();
    note(12'h110, mem.dataMem[12'h110] + 8'h01, 0);
    note(12'h020, mem.dataMem[12'h020] + 8'h01, 1);
    note(12'hf70, mem.dataMem[12'hf70] + 8'h01, 2);
    note(12'h433, mem.dataMem[12'h433] + 8'h01, 6);
    note(12'h0a5, mem.dataMem[12'h123], 8);
    note(12'h0a7, mem.dataMem[12'h125], 14);
    note(12'h040, 8'h00, 15);
    note(12'h021, 8'h00, 21);
  endtask : plan_run

  // ---------------------------------------------------------------
  // clock, monitor, timeout
  // ---------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;

  // compares each write strobe against the oldest note; checks phase of reads and fetches
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (rstn && dataWrEn) begin
      if (notes.size() == 0) begin
        check("unexpected write", {20'h0, dataAddr}, 32'hffffffff);
      end else begin
        cur = notes.pop_front();
        if (cur.gap == 0) base = cycles;
        check("write address", dataAddr, cur.addr);
        check("write data", dataWrData, cur.data);
        check("write spacing", 32'(cycles - base), 32'(4 * cur.gap));
      end
      check("write phase", phase, PH_D);
    end
    if (rstn && dataRdEn) check("read phase", phase, PH_B);
    if (rstn && (dataRdEn || dataWrEn)) begin
      check("usb buffer flag", usbBufferAccess, usbExpect);
    end
    if (rstn && progFetch) begin
      check("fetch phase", phase, PH_D);
      check("fetch pointer low bit", progAddr[0], 1'b0);
      if (lastFetch > 0) check("fetch spacing", 32'(cycles - lastFetch), 32'h4);
      lastFetch = cycles;
    end
    // a simulation that outlives its budget of 1500 clock cycles, both runs together, counts as a failure
    if (cycles >= 1500) begin
      num_errors++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  // two runs, usb engine on then off, each from a fresh reset
  initial begin
    void'($urandom(95));
    for (int run = 0; run < 2; run++) begin
      @(negedge ref_clk);
      rstn = 1'b0;
      // bank 4 sees one lone increment only, just enough to show the shared flag
      usbEnable = (run == 0);
      fill_memory();
      plan_run();
      lastFetch = 0;
      repeat (6) @(negedge ref_clk);
      rstn = 1'b1;
      for (int w = 0; w < 400 && notes.size() > 0; w++) @(negedge ref_clk);
      repeat (40) @(negedge ref_clk);
      check("pending writes", 32'(notes.size()), 32'h0);
      check("bank pointer", bankPointer, 8'h05);
      check("working register", workReg, 8'h01);
      check("zero flag", zeroFlag, 1'b0);
      $display("test run %0d done, usb engine %0d", run, usbEnable);
    end
    end_sim();
  end
endmodule : fpdb_core_tb
